// *** design/tur_test_ctrl.sv ***
// Purpose: Sequencer that programs the user register block and drives
//          the offload core's send, open and close commands.
// Assumes: Core busy rises after each accepted command.
// Notes:   Software port reads return data one cycle after the strobe.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "tur_consts.svh"

module tur_test_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Software port
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // User register block
    tur_reg_if.ctrl bus,
    // Offload core command port
    output logic core_wr,
    output logic [7:0] core_addr,
    output logic [31:0] core_wdata,
    input wire logic core_busy
);
    typedef struct packed {
        tur_pkg::tur_ctl_e st;
        logic [2:0] op;
        logic busy, done, fail;
        logic [31:0] pkl;
        logic [63:0] total, rem;
        logic [1:0] mode;
        logic [32:0] modr;
        logic [5:0] modk;
        logic [31:0] loopmax;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr, rd;
        logic core_wr;
        logic [7:0] core_addr;
        logic [31:0] core_wdata;
        logic [31:0] sw_rdata;
    } tur_ctl_s;

    tur_ctl_s s, next_s;
    logic [31:0] chunk;

    // Loop length: aligned maximum, or whatever remains on the last loop.
    always_comb begin
        if (s.rem > {32'h0000_0000, s.loopmax}) begin
            chunk = s.loopmax;
        end else begin
            chunk = s.rem[31:0];
        end
    end

    // Next-state logic for the whole sequencer and its register port.
    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.rd = 1'b0;
        next_s.core_wr = 1'b0;
        next_s.sw_rdata = 32'h0000_0000;
        if (sw_rd) begin
            case (sw_addr)
                `TUR_CS_CTRL: next_s.sw_rdata = {29'h0, s.fail, s.done,
                                                 s.busy};
                `TUR_CS_PKL: next_s.sw_rdata = s.pkl;
                `TUR_CS_TOTLO: next_s.sw_rdata = s.total[31:0];
                `TUR_CS_TOTHI: next_s.sw_rdata = s.total[63:32];
                `TUR_CS_MODE: next_s.sw_rdata = {30'h0, s.mode};
                default: next_s.sw_rdata = 32'h0000_0000;
            endcase
        end
        // Settings are frozen while an operation runs to keep loops sane.
        if (sw_wr && !s.busy) begin
            case (sw_addr)
                `TUR_CS_CTRL: begin
                    if (sw_wdata[2:0] != 3'h0) begin
                        next_s.op = sw_wdata[2:0];
                        next_s.busy = 1'b1;
                        next_s.done = 1'b0;
                        next_s.fail = 1'b0;
                        case (sw_wdata[2:0])
                            `TUR_OP_PREP: next_s.st = tur_pkg::C_PRE_LEN;
                            `TUR_OP_SEND: next_s.st = tur_pkg::C_PKL;
                            `TUR_OP_OPEN, `TUR_OP_CLOSE: begin
                                if (!s.mode[`TUR_MODE_ACTIVE_BIT]) begin
                                    next_s.st = tur_pkg::C_INT_RD;
                                end else if (sw_wdata[2:0] == `TUR_OP_OPEN)
                                begin
                                    next_s.st = tur_pkg::C_CONN_CMD;
                                end else begin
                                    next_s.st = tur_pkg::C_RX_RD;
                                end
                            end
                            default: begin
                                next_s.busy = 1'b0;
                                next_s.fail = 1'b1;
                            end
                        endcase
                    end
                end
                `TUR_CS_PKL: next_s.pkl = sw_wdata;
                `TUR_CS_TOTLO: next_s.total[31:0] = sw_wdata;
                `TUR_CS_TOTHI: next_s.total[63:32] = sw_wdata;
                `TUR_CS_MODE: next_s.mode = sw_wdata[1:0];
                default: ;
            endcase
        end
        case (s.st)
            tur_pkg::C_IDLE: ;
            // Prepare the user block: length, pattern reset, then start.
            tur_pkg::C_PRE_LEN: begin
                next_s.wr = 1'b1;
                next_s.addr = `TUR_UR_TXLEN;
                next_s.wdata = s.total[31:0];
                next_s.st = tur_pkg::C_PRE_RST;
            end
            tur_pkg::C_PRE_RST: begin
                next_s.wr = 1'b1;
                next_s.addr = `TUR_UR_RST;
                next_s.wdata = 32'h0000_0001;
                next_s.st = tur_pkg::C_PRE_CMD;
            end
            tur_pkg::C_PRE_CMD: begin
                next_s.wr = 1'b1;
                next_s.addr = `TUR_UR_CMD;
                next_s.wdata = {30'h0, s.mode[`TUR_MODE_VERIFY_BIT],
                                1'b1};
                next_s.st = tur_pkg::C_IDLE;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
            tur_pkg::C_PKL: begin
                next_s.core_wr = 1'b1;
                next_s.core_addr = `TUR_OC_PKL;
                next_s.core_wdata = s.pkl;
                next_s.rem = s.total;
                next_s.modr = 33'h0_0000_0000;
                next_s.modk = 6'h00;
                next_s.st = tur_pkg::C_MOD;
            end
            // Serial remainder of the loop limit by the packet size.
            tur_pkg::C_MOD: begin
                next_s.modr = {s.modr[31:0], 1'b1};
                if ({s.modr[31:0], 1'b1} >= {1'b0, s.pkl}) begin
                    next_s.modr = {s.modr[31:0], 1'b1} - {1'b0, s.pkl};
                end
                next_s.modk = s.modk + 6'h01;
                if (s.modk == 6'h1f) begin
                    next_s.st = tur_pkg::C_TDL;
                end
                // A zero packet size leaves the limit unaligned.
                next_s.loopmax = (s.pkl == 32'h0000_0000) ? `TUR_LOOP_LIMIT
                    : `TUR_LOOP_LIMIT - next_s.modr[31:0];
            end
            tur_pkg::C_TDL: begin
                next_s.core_wr = 1'b1;
                next_s.core_addr = `TUR_OC_TDL;
                next_s.core_wdata = chunk;
                next_s.rem = s.rem - {32'h0000_0000, chunk};
                next_s.st = tur_pkg::C_SEND;
            end
            tur_pkg::C_SEND: begin
                next_s.core_wr = 1'b1;
                next_s.core_addr = `TUR_OC_CMD;
                next_s.core_wdata = `TUR_OC_SEND;
                next_s.st = tur_pkg::C_WAIT_HI;
            end
            tur_pkg::C_CONN_CMD: begin
                next_s.core_wr = 1'b1;
                next_s.core_addr = `TUR_OC_CMD;
                next_s.core_wdata = (s.op == `TUR_OP_OPEN) ? `TUR_OC_OPEN
                                    : `TUR_OC_CLOSE;
                next_s.st = tur_pkg::C_WAIT_HI;
            end
            tur_pkg::C_WAIT_HI: begin
                if (core_busy) begin
                    next_s.st = (s.op == `TUR_OP_SEND) ? tur_pkg::C_WAIT_LO
                                : tur_pkg::C_INT_RD;
                end
            end
            tur_pkg::C_WAIT_LO: begin
                if (!core_busy) begin
                    if (s.rem == 64'h0) begin
                        next_s.st = tur_pkg::C_IDLE;
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                    end else begin
                        next_s.st = tur_pkg::C_TDL;
                    end
                end
            end
            // Active close waits for every expected byte to arrive.
            tur_pkg::C_RX_RD: begin
                next_s.rd = 1'b1;
                next_s.addr = `TUR_UR_RXLEN;
                next_s.st = tur_pkg::C_RX_CHK;
            end
            tur_pkg::C_RX_CHK: begin
                // Read data only stands once the strobe flop has dropped.
                if (s.rd) begin
                    next_s.st = tur_pkg::C_RX_CHK;
                end else if (bus.rdata == s.total[31:0]) begin
                    next_s.st = tur_pkg::C_CONN_CMD;
                end else begin
                    next_s.st = tur_pkg::C_RX_RD;
                end
            end
            tur_pkg::C_INT_RD: begin
                next_s.rd = 1'b1;
                next_s.addr = `TUR_UR_INT;
                next_s.st = tur_pkg::C_INT_CHK;
            end
            tur_pkg::C_INT_CHK: begin
                // Wait out the strobe cycle so the flag value is current.
                if (s.rd) begin
                    next_s.st = tur_pkg::C_INT_CHK;
                end else if (bus.rdata[`TUR_INT_CONN_BIT]) begin
                    next_s.st = tur_pkg::C_INT_CLR;
                end else if (s.mode[`TUR_MODE_ACTIVE_BIT] && !core_busy) begin
                    next_s.st = tur_pkg::C_IDLE;
                    next_s.busy = 1'b0;
                    next_s.fail = 1'b1;
                end else begin
                    next_s.st = tur_pkg::C_INT_RD;
                end
            end
            tur_pkg::C_INT_CLR: begin
                next_s.wr = 1'b1;
                next_s.addr = `TUR_UR_INT;
                next_s.wdata = 32'h0000_0001;
                next_s.st = tur_pkg::C_IDLE;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
            default: next_s.st = tur_pkg::C_IDLE;
        endcase
    end

    // Single state register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
            s.st <= tur_pkg::C_IDLE;
            s.loopmax <= `TUR_LOOP_LIMIT;
        end else begin
            s <= next_s;
        end
    end

    assign sw_rdata = s.sw_rdata;
    assign bus.addr = s.addr;
    assign bus.wdata = s.wdata;
    assign bus.wr = s.wr;
    assign bus.rd = s.rd;
    assign core_wr = s.core_wr;
    assign core_addr = s.core_addr;
    assign core_wdata = s.core_wdata;
endmodule : tur_test_ctrl

// *** inc/tur_consts.svh ***
// Purpose: Offsets, field positions, reset values and counts for the
//          user register block and its test controller.
// Assumes: Byte addresses on an 8-bit register port, 32-bit words.
// Notes:   Included by both design files, the monitor and the testbench.
`ifndef TUR_CONSTS_SVH
`define TUR_CONSTS_SVH

// User register block map, seen through the carrier interface.
`define TUR_UR_RST 8'h00
`define TUR_UR_CMD 8'h04
`define TUR_UR_TXLEN 8'h08
`define TUR_UR_RXLEN 8'h0c
`define TUR_UR_FFSTS 8'h10
`define TUR_UR_INT 8'h14

// Field positions.
`define TUR_RST_BIT 0
`define TUR_CMD_VERIFY_BIT 1
`define TUR_CMD_CONNON_BIT 2
`define TUR_INT_CONN_BIT 0
`define TUR_FF_RES_LSB 0
`define TUR_FF_RDCNT_LSB 6

// Pattern start value after a pattern reset.
`define TUR_PAT_START 32'h0000_0000

// Offload core command port offsets and command codes.
`define TUR_OC_CMD 8'h00
`define TUR_OC_PKL 8'h04
`define TUR_OC_TDL 8'h08
`define TUR_OC_SEND 32'h0000_0000
`define TUR_OC_OPEN 32'h0000_0002
`define TUR_OC_CLOSE 32'h0000_0003

// Largest loop length before alignment to the packet size (4 GB less one).
`define TUR_LOOP_LIMIT 32'hffff_ffff

// Controller software map.
`define TUR_CS_CTRL 8'h00
`define TUR_CS_PKL 8'h04
`define TUR_CS_TOTLO 8'h08
`define TUR_CS_TOTHI 8'h0c
`define TUR_CS_MODE 8'h10
`define TUR_OP_PREP 3'h1
`define TUR_OP_OPEN 3'h2
`define TUR_OP_SEND 3'h3
`define TUR_OP_CLOSE 3'h4
`define TUR_MODE_VERIFY_BIT 0
`define TUR_MODE_ACTIVE_BIT 1

`endif

// *** inc/tur_pkg.sv ***
// Purpose: Shared types for the user register block and its controller.
// Assumes: Constants come from tur_consts.svh.
// Notes:   Only the controller state type is shared.
package tur_pkg;
    // Controller sequencing states.
    typedef enum logic [4:0] {
        C_IDLE, C_PRE_LEN, C_PRE_RST, C_PRE_CMD, C_PKL, C_MOD, C_TDL,
        C_SEND, C_WAIT_HI, C_WAIT_LO, C_RX_RD, C_RX_CHK, C_CONN_CMD,
        C_INT_RD, C_INT_CHK, C_INT_CLR
    } tur_ctl_e;
endpackage : tur_pkg

// *** inc/tur_reg_if.sv ***
// Purpose: Register port between the test controller and the user
//          register block.
// Assumes: Read data is valid the cycle after the read strobe.
// Notes:   One modport per party, no clocking block.
`timescale 1ns/1ps
interface tur_reg_if;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;

    // Controller side drives the strobes.
    modport ctrl (output addr, output wdata, output wr, output rd,
                  input rdata);
    // User register block answers.
    modport user (input addr, input wdata, input wr, input rd,
                  output rdata);
endinterface : tur_reg_if

// *** design/tur_user_regs.sv ***
// Purpose: User register block with a 32-bit incrementing pattern
//          generator and verifier around an offload core's data ports.
// Assumes: Core inputs are synchronous to clk; receive data arrives the
//          cycle after a read enable pulse.
// Notes:   One receive read is outstanding at a time, which trades peak
//          drain rate for a design that never over-reads the FIFO.
`timescale 1ns/1ps
`include "tur_consts.svh"

// Function
// - Reset bit restarts generator and verifier pattern.
// - Command bit 1 selects drain or verify.
// - Command bit 2 reads live connection state.
// - Received byte counter readable at any time.
// - FIFO status 19:6 mirrors readable words.
// - FIFO status 5:0 mirrors residual count.
// - Command bit 1 reads verify error.
// - Command write starts the transmit generator.
// - Transmit length set, then reads bytes sent.
// - Data is a 32-bit incrementing pattern.
// - Transmit and receive run concurrently.
// - Controller writes packet length before sending.
// - Loop lengths aligned, at most 4GB.
// - Each loop starts with send command.
// - Busy high while executing, polled before next.
// - Active close waits full receive; checks interrupt.
// - Interrupt bit sets on remote close.
// - Interrupt stays set until software clears.
// - Active open uses command code two.
// - Active close uses command code three.
module tur_user_regs #(
    parameter int DATA_W = 512,
    parameter int RDCNT_W = 14,
    parameter int RES_W = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port from the controller
    tur_reg_if.user bus,
    // Transmit stream to the offload core
    output logic [DATA_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Receive FIFO of the offload core
    output logic rx_rd_en,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic [RDCNT_W-1:0] rx_fifo_readable_words,
    input wire logic [RES_W-1:0] rx_fifo_residual_count,
    // Connection state and status outputs
    input wire logic conn_on,
    output logic verify_error,
    output logic connection_interrupt_flag
);
    localparam int WORDS = DATA_W / 32;
    localparam logic [31:0] BEAT_BYTES = 32'(DATA_W / 8);
    localparam logic [31:0] BEAT_WORDS = 32'(WORDS);

    typedef struct packed {
        logic [DATA_W-1:0] tx_data;
        logic tx_valid;
        logic tx_run;
        logic [31:0] tx_total;
        logic [31:0] tx_sent;
        logic [31:0] tx_base;
        logic [31:0] rx_exp;
        logic [31:0] rx_cnt;
        logic verify_en;
        logic err;
        logic rst_bit;
        logic rd_en;
        logic rd_pend;
        logic conn;
        logic int_flag;
        logic [19:0] ffsts;
        logic [31:0] rdata;
    } tur_ur_s;

    tur_ur_s s, next_s;

    // One beat of the pattern: consecutive 32-bit words from base.
    function automatic logic [DATA_W-1:0] tur_pattern(
        input logic [31:0] base
    );
        logic [DATA_W-1:0] v;
        v = '0;
        for (int i = 0; i < WORDS; i++) begin
            v[i*32 +: 32] = base + 32'(i);
        end
        return v;
    endfunction : tur_pattern

    // Next-state logic: register access, generator, drain and verifier.
    always_comb begin
        logic [31:0] rem;
        logic [31:0] step;
        logic [31:0] sent;
        rem = 32'h0000_0000;
        step = 32'h0000_0000;
        sent = 32'h0000_0000;
        next_s = s;
        next_s.rd_en = 1'b0;
        next_s.rdata = 32'h0000_0000;

        // Transmit: a beat leaves when the core takes it.
        sent = s.tx_sent;
        if (s.tx_valid && tx_ready) begin
            rem = s.tx_total - s.tx_sent;
            step = (rem < BEAT_BYTES) ? rem : BEAT_BYTES;
            sent = s.tx_sent + step;
            next_s.tx_sent = sent;
            next_s.tx_base = s.tx_base + BEAT_WORDS;
        end
        next_s.tx_data = tur_pattern(next_s.tx_base);
        next_s.tx_valid = s.tx_run && (sent < s.tx_total);

        // Receive: pop whenever words are readable, one at a time.
        if (rx_valid) begin
            next_s.rd_pend = 1'b0;
            next_s.rx_cnt = s.rx_cnt + BEAT_BYTES;
            next_s.rx_exp = s.rx_exp + BEAT_WORDS;
        end
        if (!s.rd_pend && !s.rd_en &&
            rx_fifo_readable_words != '0) begin
            next_s.rd_en = 1'b1;
            next_s.rd_pend = 1'b1;
        end

        // FIFO status mirrors and live connection state.
        next_s.ffsts = {rx_fifo_readable_words[13:0],
                        rx_fifo_residual_count[5:0]};
        next_s.conn = conn_on;

        // Register writes; the pattern reset also clears the counts.
        if (bus.wr) begin
            case (bus.addr)
                `TUR_UR_RST: begin
                    next_s.rst_bit = bus.wdata[`TUR_RST_BIT];
                    if (bus.wdata[`TUR_RST_BIT]) begin
                        next_s.tx_base = `TUR_PAT_START;
                        next_s.rx_exp = `TUR_PAT_START;
                        next_s.tx_data = tur_pattern(`TUR_PAT_START);
                        next_s.tx_run = 1'b0;
                        next_s.tx_valid = 1'b0;
                        next_s.tx_sent = 32'h0000_0000;
                        next_s.rx_cnt = 32'h0000_0000;
                        next_s.err = 1'b0;
                    end
                end
                `TUR_UR_CMD: begin
                    next_s.verify_en = bus.wdata[`TUR_CMD_VERIFY_BIT];
                    next_s.tx_run = 1'b1;
                    next_s.tx_sent = 32'h0000_0000;
                end
                `TUR_UR_TXLEN: next_s.tx_total = bus.wdata;
                `TUR_UR_INT: begin
                    if (bus.wdata[`TUR_INT_CONN_BIT]) begin
                        next_s.int_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Hardware sets come after clears so an event is never lost.
        if (rx_valid && s.verify_en &&
            rx_data != tur_pattern(s.rx_exp)) begin
            next_s.err = 1'b1;
        end
        if (conn_on != s.conn) begin
            next_s.int_flag = 1'b1;
        end

        // Read data stands in the cycle after the strobe.
        if (bus.rd) begin
            case (bus.addr)
                `TUR_UR_RST: next_s.rdata = {31'h0, s.rst_bit};
                `TUR_UR_CMD: next_s.rdata = {29'h0, s.conn, s.err,
                                             s.tx_run};
                `TUR_UR_TXLEN: next_s.rdata = s.tx_sent;
                `TUR_UR_RXLEN: next_s.rdata = s.rx_cnt;
                `TUR_UR_FFSTS: next_s.rdata = {12'h000, s.ffsts};
                `TUR_UR_INT: next_s.rdata = {31'h0, s.int_flag};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Single state register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.rdata = s.rdata;
    assign tx_data = s.tx_data;
    assign tx_valid = s.tx_valid;
    assign rx_rd_en = s.rd_en;
    assign verify_error = s.err;
    assign connection_interrupt_flag = s.int_flag;
endmodule : tur_user_regs

// *** bench/tur_monitor.sv ***
// Purpose: Watches the register port between controller and block.
// Assumes: All signals are sampled on the rising clock edge.
// Notes:   Instantiated beside the carrier by the testbench.
`timescale 1ns/1ps
`include "tur_consts.svh"
module tur_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Preparation is three writes on consecutive cycles.
    sequence s_len; wr && addr == `TUR_UR_TXLEN; endsequence
    sequence s_rst; wr && addr == `TUR_UR_RST && wdata[0]; endsequence
    sequence s_go; wr && addr == `TUR_UR_CMD && wdata[0]; endsequence
    a_prep_order: assert property (s_len |=> s_rst ##1 s_go)
        else $error("preparation writes out of order");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("read and write strobes together");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its slot");
    a_int_width: assert property ($past(rd) && $past(addr) == `TUR_UR_INT
        |-> rdata[31:1] == 31'h0)
        else $error("interrupt register upper bits set");
    a_cmd_start: assert property (wr && addr == `TUR_UR_CMD |->
        wdata[0])
        else $error("command write without start bit");
    a_int_clear: assert property (wr && addr == `TUR_UR_INT |->
        wdata[0])
        else $error("interrupt clear without bit 0");
    a_rd_map: assert property (rd |->
        addr == `TUR_UR_INT || addr == `TUR_UR_RXLEN)
        else $error("controller polled an unexpected register");
    a_poll_gap: assert property (rd |=> !rd)
        else $error("polls closer than two cycles");
endmodule : tur_monitor

// *** bench/testbench.sv ***
// Purpose: Runs controller and register block against a core model.
// Assumes: Status reads show bit 1 once an operation has finished.
// Notes:   One receive beat is corrupted to exercise the verifier.
`timescale 1ns/1ps
`include "tur_consts.svh"
module testbench;
    logic clk, rstn, sw_wr, sw_rd, core_wr, core_busy, tx_ready, rx_valid;
    logic conn_on, tx_valid, rx_rd_en, verify_error, rd_pend;
    logic connection_interrupt_flag;
    logic [7:0] sw_addr, core_addr;
    logic [31:0] sw_wdata, sw_rdata, core_wdata;
    logic [511:0] tx_data, rx_data;
    logic [13:0] rx_fifo_readable_words;
    logic [5:0] rx_fifo_residual_count;
    int mismatches, compares, seed, rx_beat, cmd_done;
    logic [31:0] rd_q[$];
    logic [39:0] core_q[$];
    logic [511:0] tx_q[$];
    tur_reg_if bus ();
    tur_test_ctrl tur_test_ctrl_i (.clk, .rstn, .sw_addr, .sw_wdata, .sw_wr,
        .sw_rd, .sw_rdata, .bus, .core_wr, .core_addr, .core_wdata,
        .core_busy);
    tur_user_regs tur_user_regs_i (.clk, .rstn, .bus, .tx_data, .tx_valid,
        .tx_ready, .rx_rd_en, .rx_data, .rx_valid, .rx_fifo_readable_words,
        .rx_fifo_residual_count, .conn_on, .verify_error,
        .connection_interrupt_flag);
    tur_monitor tur_monitor_i (.clk, .rstn, .addr(bus.addr),
        .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
    // Free running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Sixteen words counting up from the given base.
    function automatic logic [511:0] pat(input logic [31:0] b);
        for (int i = 0; i < 16; i++) pat[i*32 +: 32] = b + i;
    endfunction : pat
    task automatic chk(input string name, input logic [511:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task complete_run;
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Strobes are released a full cycle before the next request.
    task sw_write(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        @(posedge clk);
    endtask : sw_write
    task sw_read(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(posedge clk);
    endtask : sw_read
    // Bounded wait on finished core commands and consumed beats.
    task waitfor(input int n, input int r);
        int k;
        for (k = 0; k < 3000 && (cmd_done < n || rx_beat < r); k++)
            @(posedge clk);
        if (k == 3000) begin
            mismatches++;
            complete_run();
        end
        repeat (12) @(posedge clk);
    endtask : waitfor
    task op(input logic [2:0] code, input int n);
        sw_write(`TUR_CS_CTRL, {29'h0, code});
        waitfor(n, 0);
        sw_read(`TUR_CS_CTRL, 32'h2);
    endtask : op
    // Result watchers take the oldest note whenever a result shows.
    always @(posedge clk) begin
        if (rd_pend) chk("sw_rdata", sw_rdata, rd_q.pop_front());
        rd_pend <= sw_rd;
        if (core_wr)
            chk("core", {core_addr, core_wdata}, core_q.pop_front());
        if (tx_valid && tx_ready) chk("tx", tx_data, tx_q.pop_front());
        tx_ready <= 1'($random(seed));
        // Receive FIFO answers one cycle after each pop.
        rx_valid <= rx_rd_en;
        if (rx_rd_en) begin
            rx_data <= pat(rx_beat * 16) ^ {511'h0, rx_beat == 2};
            rx_beat <= rx_beat + 1;
            rx_fifo_readable_words <= rx_fifo_readable_words - 14'h1;
        end
    end
    // Core model: busy rises two cycles after a command, state follows.
    initial begin
        forever begin
            @(posedge clk);
            if (core_wr && core_addr == `TUR_OC_CMD) begin
                repeat (2) @(posedge clk);
                core_busy <= 1'b1;
                repeat (2 + $unsigned($random(seed)) % 8) @(posedge clk);
                if (core_wdata == `TUR_OC_OPEN) conn_on <= 1'b1;
                if (core_wdata == `TUR_OC_CLOSE) conn_on <= 1'b0;
                repeat (4) @(posedge clk);
                core_busy <= 1'b0;
                cmd_done++;
            end
        end
    end
    initial begin
        seed = 32'h48274a73;
        {rstn, sw_wr, sw_rd, core_busy, tx_ready, conn_on, rd_pend} = 7'h0;
        {sw_addr, sw_wdata, rx_data, rx_valid} = '0;
        rx_fifo_readable_words = 14'h0;
        rx_fifo_residual_count = 6'($random(seed));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        sw_write(`TUR_CS_PKL, 32'h40);
        sw_write(`TUR_CS_TOTLO, 32'h100);
        sw_write(`TUR_CS_TOTHI, 32'h0);
        sw_write(`TUR_CS_MODE, 32'h3);
        for (int i = 0; i < 4; i++) tx_q.push_back(pat(i * 16));
        op(`TUR_OP_PREP, 0);
        core_q.push_back({`TUR_OC_CMD, `TUR_OC_OPEN});
        op(`TUR_OP_OPEN, 1);
        chk("int_flag", connection_interrupt_flag, 0);
        rx_fifo_readable_words <= 14'h4;
        core_q.push_back({`TUR_OC_PKL, 32'h40});
        core_q.push_back({`TUR_OC_TDL, 32'h100});
        core_q.push_back({`TUR_OC_CMD, `TUR_OC_SEND});
        op(`TUR_OP_SEND, 2);
        waitfor(2, 4);
        chk("verify_error", verify_error, 1);
        core_q.push_back({`TUR_OC_CMD, `TUR_OC_CLOSE});
        op(`TUR_OP_CLOSE, 3);
        chk("int_flag", connection_interrupt_flag, 0);
        chk("verify_error", verify_error, 1);
        for (int i = 0; i < 4; i++) tx_q.push_back(pat(i * 16));
        op(`TUR_OP_PREP, 3);
        chk("verify_error", verify_error, 0);
        repeat (40) @(posedge clk);
        chk("tx_left", tx_q.size(), 0);
        complete_run();
    end
endmodule : testbench
